// File: bench/drive_status_asserts.sv
/*
 Port-level assertions for the status output selector.
 Assumes one clock and the synchronous reset of the selector.
*/
`timescale 1ns/1ps
`include "drive_status_defines.svh"

module drive_status_checker #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // settings and causes
    input wire logic cfg_wr_i,
    input wire drive_status_pkg::fn_code_t collector_output_function_i,
    input wire drive_status_pkg::fn_code_t relay_function_i,
    input wire drive_status_pkg::delay_t trip_assert_delay_i,
    input wire logic run_cmd_i,
    input wire logic voltage_out_i,
    input wire logic dc_braking_i,
    input wire logic buffering_start_i,
    input wire logic power_restored_i,
    input wire logic low_voltage_trip_i,
    input wire logic other_trip_i,
    input wire logic restart_fail_i,
    input wire logic fault_reset_i,
    // outputs watched
    input wire logic open_collector_output_o,
    input wire logic relay_output_o,
    input wire logic trip_latched_o,
    input wire logic trip_active_o,
    input wire logic kinetic_energy_buffering_o,
    input wire logic [2:0] trip_cause_mask_o
);
    drive_status_pkg::fn_code_t oc_fn_q;
    drive_status_pkg::fn_code_t rl_fn_q;
    logic adly_zero_q;
    logic [2:0] cause;

    assign cause = {restart_fail_i, other_trip_i, low_voltage_trip_i};

    // shadow of the loaded codes, same timing as the selector's own
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            oc_fn_q <= `RST_COLLECTOR_FN;
            rl_fn_q <= `RST_RELAY_FN;
            adly_zero_q <= 1'b1;
        end else if (cfg_wr_i) begin
            oc_fn_q <= collector_output_function_i;
            rl_fn_q <= relay_function_i;
            adly_zero_q <= (trip_assert_delay_i == `RST_DELAY);
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    chk_run_select: assert property ((oc_fn_q == `FN_RUN) |=>
        open_collector_output_o == $past(run_cmd_i && voltage_out_i && !dc_braking_i))
        else $error("run selection mismatch");
    chk_stop_select: assert property ((oc_fn_q == `FN_STOP) |=>
        open_collector_output_o == $past(!run_cmd_i && !voltage_out_i))
        else $error("stop selection mismatch");
    chk_trip_capture: assert property ((|(trip_cause_mask_o & cause)) |=>
        trip_latched_o)
        else $error("enabled trip cause not latched");
    chk_latch_clear: assert property ($fell(trip_latched_o) |->
        $past(fault_reset_i) && !$past(|(trip_cause_mask_o & cause)))
        else $error("trip latch cleared without fault reset");
    chk_zero_delay: assert property ((adly_zero_q && $rose(trip_latched_o)) |=>
        trip_active_o)
        else $error("zero assert delay not honoured");
    chk_trip_route: assert property ((rl_fn_q == `FN_TRIP) |=>
        relay_output_o == $past(trip_active_o))
        else $error("relay does not follow trip");
    chk_none_quiet: assert property ((oc_fn_q == `FN_NONE) |=>
        !open_collector_output_o)
        else $error("unselected output driven");
    chk_mask_default: assert property ($fell(srst_i) |->
        trip_cause_mask_o == `RST_CAUSE_MASK)
        else $error("cause mask reset value wrong");
    chk_buffer_start: assert property (buffering_start_i |=>
        kinetic_energy_buffering_o)
        else $error("buffering not entered");
    chk_buffer_hold: assert property ((kinetic_energy_buffering_o && !power_restored_i) |=>
        kinetic_energy_buffering_o)
        else $error("buffering dropped before power return");

    cover property ($rose(relay_output_o));
    cover property ($rose(trip_active_o) && !adly_zero_q);
    cover property ($rose(kinetic_energy_buffering_o));
endmodule : drive_status_checker

bind drive_status_output_selector drive_status_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_sys_i, .srst_i, .cfg_wr_i, .collector_output_function_i, .relay_function_i,
    .trip_assert_delay_i, .run_cmd_i, .voltage_out_i, .dc_braking_i, .buffering_start_i,
    .power_restored_i, .low_voltage_trip_i, .other_trip_i, .restart_fail_i, .fault_reset_i,
    .open_collector_output_o, .relay_output_o, .trip_latched_o, .trip_active_o,
    .kinetic_energy_buffering_o, .trip_cause_mask_o
);

// File: bench/status_load_model.sv
/*
 Loads on the two outputs: a pulled-up line on the transistor output
 and a relay contact. Assumes level outputs from the selector.
*/
`timescale 1ns/1ps

module status_load_model (
    // from the selector
    input wire logic oc_drive_i,
    input wire logic relay_coil_i,
    // seen by the load
    output logic collector_line_o,
    output logic contact_closed_o
);
    // pull-up holds the line high whenever the transistor is off
    assign collector_line_o = !oc_drive_i;
    assign contact_closed_o = relay_coil_i;
endmodule : status_load_model

// File: bench/tb_top.sv
/*
 Self-checking bench for the status output selector.
 Assumes the bound checker and a ten-cycle tick for short delays.
*/
`timescale 1ns/1ps
`include "drive_status_defines.svh"

module tb_top;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic cfg_wr_i = 1'b0;
    drive_status_pkg::fn_code_t oc_fn = `RST_COLLECTOR_FN;
    drive_status_pkg::fn_code_t rl_fn = `RST_RELAY_FN;
    logic [2:0] mask = `RST_CAUSE_MASK;
    drive_status_pkg::delay_t adly = `RST_DELAY;
    drive_status_pkg::delay_t rdly = `RST_DELAY;
    drive_status_pkg::delay_t tdly = `RST_DELAY;
    logic [11:0] on_lvl = 12'h000;
    logic [11:0] off_lvl = 12'h000;
    logic [11:0] analog = 12'h000;
    logic [8:0] lv = 9'h000;
    logic [2:0] cause = 3'h0;
    logic trig = 1'b0;
    logic buf_start = 1'b0;
    logic pwr_back = 1'b0;
    logic fault_rst = 1'b0;
    logic oc_o, relay_o, latched_o, active_o, buf_o, line_o, contact_o;
    logic [2:0] mask_o;
    int errors = 0;
    int cmp_count = 0;
    drive_status_pkg::fn_code_t codes [8] = '{`FN_RUN, `FN_STOP, `FN_STEADY, `FN_INV_LINE,
        `FN_COMM_LINE, `FN_SEARCH, `FN_READY, `FN_BRAKE};
    logic [8:0] on_v [8] = '{9'h003, 9'h000, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100};
    logic [8:0] off_v [8] = '{9'h007, 9'h002, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000};

    drive_status_output_selector #(.TICK_CYCLES(10), .ANALOG_W(12)) dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .cfg_wr_i(cfg_wr_i),
        .collector_output_function_i(oc_fn), .relay_function_i(rl_fn),
        .trip_cause_mask_i(mask), .trip_assert_delay_i(adly), .trip_release_delay_i(rdly),
        .timer_delay_i(tdly), .on_level_i(on_lvl), .off_level_i(off_lvl),
        .run_cmd_i(lv[0]), .voltage_out_i(lv[1]), .dc_braking_i(lv[2]), .steady_i(lv[3]),
        .inverter_line_i(lv[4]), .comm_line_i(lv[5]), .speed_search_i(lv[6]),
        .ready_i(lv[7]), .timer_trigger_i(trig), .analog_value_i(analog),
        .brake_release_output_i(lv[8]), .buffering_start_i(buf_start),
        .power_restored_i(pwr_back), .low_voltage_trip_i(cause[0]),
        .other_trip_i(cause[1]), .restart_fail_i(cause[2]), .fault_reset_i(fault_rst),
        .open_collector_output_o(oc_o), .relay_output_o(relay_o),
        .trip_latched_o(latched_o), .trip_active_o(active_o),
        .kinetic_energy_buffering_o(buf_o), .trip_cause_mask_o(mask_o)
    );

    status_load_model load (
        .oc_drive_i(oc_o), .relay_coil_i(relay_o),
        .collector_line_o(line_o), .contact_closed_o(contact_o)
    );

    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc

    // sample half a cycle after the edge, once its updates have landed
    task automatic look(input int n);
        cyc(n);
        @(negedge clk_sys_i);
    endtask : look

    task automatic conclude();
        $display("comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask : chk

    task automatic wait_for(input string nm, input logic on_trip, input logic v, input int lim);
        int i;
        i = 0;
        while ((on_trip ? active_o : oc_o) !== v && i < lim) begin
            @(negedge clk_sys_i);
            i++;
        end
        chk(nm, v, on_trip ? active_o : oc_o);
        if (i >= lim && (on_trip ? active_o : oc_o) !== v) begin
            conclude();
        end
    endtask : wait_for

    task automatic cfg(input drive_status_pkg::fn_code_t o, input drive_status_pkg::fn_code_t r,
        input logic [2:0] m, input drive_status_pkg::delay_t a, input drive_status_pkg::delay_t d);
        oc_fn <= o;
        rl_fn <= r;
        mask <= m;
        adly <= a;
        rdly <= d;
        cfg_wr_i <= 1'b1;
        cyc(1);
        cfg_wr_i <= 1'b0;
        cyc(1);
    endtask : cfg

    initial begin
        cyc(2);
        srst_i <= 1'b0;
        look(1);
        chk("mask at reset", 1'b1, mask_o === `RST_CAUSE_MASK);
        chk("relay at reset", 1'b0, contact_o);
        for (int k = 0; k < 8; k++) begin
            cyc(1);
            cfg(codes[k], `RST_RELAY_FN, `RST_CAUSE_MASK, `RST_DELAY, `RST_DELAY);
            lv <= on_v[k];
            look(1);
            chk("direct on", 1'b1, oc_o);
            cyc(1);
            lv <= off_v[k];
            look(1);
            chk("direct off", 1'b0, oc_o);
        end
        for (int b = 0; b < 3; b++) begin
            cyc(1);
            cfg(`FN_NONE, `FN_TRIP, 3'h1 << b, `RST_DELAY, `RST_DELAY);
            cause <= ~(3'h1 << b);
            look(3);
            chk("masked trip", 1'b0, relay_o);
            cyc(1);
            cause <= 3'h1 << b;
            look(3);
            chk("relay trip", 1'b1, relay_o);
            chk("collector none", 1'b0, oc_o);
            cyc(1);
            cause <= 3'h0;
            fault_rst <= 1'b1;
            cyc(1);
            fault_rst <= 1'b0;
            look(3);
            chk("relay clear", 1'b0, relay_o);
        end
        cyc(1);
        cfg(`FN_TRIP, `FN_TRIP, `RST_CAUSE_MASK, 14'h0003, 14'h0002);
        cause <= 3'h2;
        cyc(1);
        cause <= 3'h0;
        look(15);
        chk("early assert", 1'b0, active_o);
        wait_for("delayed assert", 1'b1, 1'b1, 40);
        look(1);
        chk("collector trip", 1'b1, oc_o);
        cyc(1);
        fault_rst <= 1'b1;
        cyc(1);
        fault_rst <= 1'b0;
        look(5);
        chk("early release", 1'b1, active_o);
        wait_for("delayed release", 1'b1, 1'b0, 30);
        cyc(1);
        cause <= 3'h2;
        cyc(1);
        cause <= 3'h0;
        fault_rst <= 1'b1;
        cyc(1);
        fault_rst <= 1'b0;
        look(40);
        chk("cancelled trip", 1'b0, active_o);
        cyc(1);
        cfg(`FN_BUFFERING, `FN_TRIP, `RST_CAUSE_MASK, `RST_DELAY, `RST_DELAY);
        buf_start <= 1'b1;
        cyc(1);
        buf_start <= 1'b0;
        look(8);
        chk("buffering held", 1'b1, oc_o);
        chk("line pulled low", 1'b0, line_o);
        cyc(1);
        pwr_back <= 1'b1;
        cyc(1);
        pwr_back <= 1'b0;
        look(2);
        chk("buffering end", 1'b0, oc_o);
        cyc(1);
        tdly <= 14'h0002;
        cfg(`FN_TIMER, `FN_TRIP, `RST_CAUSE_MASK, `RST_DELAY, `RST_DELAY);
        trig <= 1'b1;
        look(5);
        chk("timer early", 1'b0, oc_o);
        wait_for("timer", 1'b0, 1'b1, 40);
        cyc(1);
        trig <= 1'b0;
        look(2);
        chk("timer drop", 1'b0, oc_o);
        cyc(1);
        on_lvl <= 12'h064;
        off_lvl <= 12'h032;
        cfg(`FN_ON_OFF, `FN_TRIP, `RST_CAUSE_MASK, `RST_DELAY, `RST_DELAY);
        analog <= 12'h078;
        look(2);
        chk("on level", 1'b1, oc_o);
        cyc(1);
        analog <= 12'h046;
        look(2);
        chk("between levels", 1'b1, oc_o);
        cyc(1);
        analog <= 12'h028;
        look(2);
        chk("off level", 1'b0, oc_o);
        cyc(1);
        cfg(`FN_NONE, `FN_TRIP, 3'h5, `RST_DELAY, `RST_DELAY);
        look(0);
        chk("mask load", 1'b1, mask_o === 3'h5);
        cyc(1);
        srst_i <= 1'b1;
        cyc(2);
        srst_i <= 1'b0;
        look(1);
        chk("mask after reset", 1'b1, mask_o === `RST_CAUSE_MASK);
        conclude();
    end
endmodule : tb_top

// File: logic/drive_status_defines.svh
/*
 Constants for the drive status output selector: function codes, config
 reset values, delay limits and the time-base figures.
 Assumes a single 25 MHz system clock.
*/
// Behaviour
// R1: code 15 asserts while run command off and no output voltage.
// R2: code 16 asserts during steady-speed operation.
// R3: code 17 asserts while motor runs from the drive output stage.
// R4: code 18 asserts while motor runs directly from commercial mains.
// R5: code 19 asserts throughout speed search.
// R6: code 22 asserts while in standby, ready for an external run command.
// R7: code 28 follows the timer, asserting a set time after its trigger.
// R8: code 29 asserts after a fault trip.
// R9: code 34 follows an on/off comparison of an analog input value.
// R10: code 35 carries the mechanical brake release signal.
// R11: code 40 asserts once energy buffering starts after input power loss.
// R12: buffering indication holds until power returns, whatever buffering mode.
// R13: trip state reaches an output only when its function code is 29.
// R14: mask bit1 enables trip output on low-voltage trips.
// R15: mask bit2 enables trip output on all other fault trips.
// R16: mask bit3 enables trip output when automatic restart fails.
// R17: trip cause mask resets to 010.
// R18: trip assertion delay 0.00 to 100.00 s, default 0.00.
// R19: trip release delay 0.00 to 100.00 s, default 0.00.
// R20: code 14 asserts on run command with output voltage, not during DC braking.
// R21: fault trip waits the assertion delay before operating the output.
// R22: after fault clear and reinitialisation, output drops after the release delay.
// R23: delays count 10 ms ticks; a toggle of the condition restarts the count.
`ifndef DRIVE_STATUS_DEFINES_SVH
`define DRIVE_STATUS_DEFINES_SVH

`define FN_NONE 6'h00
`define FN_RUN 6'h0E
`define FN_STOP 6'h0F
`define FN_STEADY 6'h10
`define FN_INV_LINE 6'h11
`define FN_COMM_LINE 6'h12
`define FN_SEARCH 6'h13
`define FN_READY 6'h16
`define FN_TIMER 6'h1C
`define FN_TRIP 6'h1D
`define FN_ON_OFF 6'h22
`define FN_BRAKE 6'h23
`define FN_BUFFERING 6'h28

`define CAUSE_LOW_VOLT 0
`define CAUSE_OTHER 1
`define CAUSE_RESTART 2

`define RST_CAUSE_MASK 3'h2
`define RST_COLLECTOR_FN 6'h0E
`define RST_RELAY_FN 6'h1D
`define RST_DELAY 14'h0000
`define DELAY_MAX 14'h2710

`define CLK_HZ 25000000
`define TICK_MS 10
`define TICK_CYCLES (`CLK_HZ / 1000 * `TICK_MS)

`endif

// File: logic/drive_status_output_selector.sv
/*
 Chooses which drive status condition drives the open-collector output
 and the relay, qualifies fault trips by a cause mask and delays them.
 Assumes status flags are synchronous to clk_sys_i and that settings
 are presented together with a one-cycle cfg_wr_i strobe.
*/
`timescale 1ns/1ps
`include "drive_status_defines.svh"

module drive_status_output_selector #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
    parameter int unsigned ANALOG_W = 12
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,

    // settings, loaded on cfg_wr_i
    input wire logic cfg_wr_i,
    input wire drive_status_pkg::fn_code_t collector_output_function_i,
    input wire drive_status_pkg::fn_code_t relay_function_i,
    input wire logic [2:0] trip_cause_mask_i,
    input wire drive_status_pkg::delay_t trip_assert_delay_i,
    input wire drive_status_pkg::delay_t trip_release_delay_i,
    input wire drive_status_pkg::delay_t timer_delay_i,
    input wire logic [ANALOG_W-1:0] on_level_i,
    input wire logic [ANALOG_W-1:0] off_level_i,

    // run state from the controller
    input wire logic run_cmd_i,
    input wire logic voltage_out_i,
    input wire logic dc_braking_i,
    input wire logic steady_i,
    input wire logic inverter_line_i,
    input wire logic comm_line_i,
    input wire logic speed_search_i,
    input wire logic ready_i,

    // timer, analog and brake
    input wire logic timer_trigger_i,
    input wire logic [ANALOG_W-1:0] analog_value_i,
    input wire logic brake_release_output_i,

    // energy buffering
    input wire logic buffering_start_i,
    input wire logic power_restored_i,

    // fault trips
    input wire logic low_voltage_trip_i,
    input wire logic other_trip_i,
    input wire logic restart_fail_i,
    input wire logic fault_reset_i,

    // outputs to the loads
    output logic open_collector_output_o,
    output logic relay_output_o,

    // state seen by the controller
    output logic trip_latched_o,
    output logic trip_active_o,
    output logic kinetic_energy_buffering_o,
    output logic [2:0] trip_cause_mask_o
);

    // settings
    drive_status_pkg::fn_code_t collector_fn_q;
    drive_status_pkg::fn_code_t relay_fn_q;
    logic [2:0] cause_mask_q;
    drive_status_pkg::delay_t assert_dly_q;
    drive_status_pkg::delay_t release_dly_q;
    drive_status_pkg::delay_t timer_dly_q;
    logic [ANALOG_W-1:0] on_level_q;
    logic [ANALOG_W-1:0] off_level_q;

    // internal state
    logic tick;
    logic trip_cause;
    logic trip_latched_q;
    logic trip_delayed;
    logic timer_delayed;
    logic on_off_q;
    logic buffering_q;
    logic collector_q;
    logic relay_q;
    drive_status_pkg::status_t status;

    // out-of-range delays are held at 100.00 s rather than wrapping
    function automatic drive_status_pkg::delay_t clamp_delay(
        input drive_status_pkg::delay_t value
    );
        clamp_delay = (value > `DELAY_MAX) ? `DELAY_MAX : value;
    endfunction : clamp_delay

    // one condition for a function code; unknown codes give no output
    function automatic logic pick(
        input drive_status_pkg::fn_code_t code,
        input drive_status_pkg::status_t st
    );
        case (code)
            `FN_RUN: pick = st.run; // R20
            `FN_STOP: pick = st.stop; // R1
            `FN_STEADY: pick = st.steady; // R2
            `FN_INV_LINE: pick = st.inv_line; // R3
            `FN_COMM_LINE: pick = st.comm_line; // R4
            `FN_SEARCH: pick = st.search; // R5
            `FN_READY: pick = st.ready; // R6
            `FN_TIMER: pick = st.timer; // R7
            `FN_TRIP: pick = st.trip; // R13
            `FN_ON_OFF: pick = st.on_off; // R9
            `FN_BRAKE: pick = st.brake; // R10
            `FN_BUFFERING: pick = st.buffering; // R11
            default: pick = 1'b0;
        endcase
    endfunction : pick

    // settings registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            collector_fn_q <= `RST_COLLECTOR_FN;
            relay_fn_q <= `RST_RELAY_FN;
        end else if (cfg_wr_i) begin
            collector_fn_q <= collector_output_function_i;
            relay_fn_q <= relay_function_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cause_mask_q <= `RST_CAUSE_MASK; // R17
        end else if (cfg_wr_i) begin
            cause_mask_q <= trip_cause_mask_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            assert_dly_q <= `RST_DELAY; // R18
            release_dly_q <= `RST_DELAY; // R19
            timer_dly_q <= `RST_DELAY;
        end else if (cfg_wr_i) begin
            assert_dly_q <= clamp_delay(trip_assert_delay_i); // R18
            release_dly_q <= clamp_delay(trip_release_delay_i); // R19
            timer_dly_q <= clamp_delay(timer_delay_i);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            on_level_q <= '0;
            off_level_q <= '0;
        end else if (cfg_wr_i) begin
            on_level_q <= on_level_i;
            off_level_q <= off_level_i;
        end
    end

    // time base
    tick_divider #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .tick_o(tick)
    );

    // fault trip qualification
    assign trip_cause = (cause_mask_q[`CAUSE_LOW_VOLT] & low_voltage_trip_i) | // R14
                        (cause_mask_q[`CAUSE_OTHER] & other_trip_i) | // R15
                        (cause_mask_q[`CAUSE_RESTART] & restart_fail_i); // R16

    // a trip stays until reset; a new cause in the reset cycle wins
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            trip_latched_q <= 1'b0;
        end else if (trip_cause) begin
            trip_latched_q <= 1'b1; // R8
        end else if (fault_reset_i) begin
            trip_latched_q <= 1'b0; // R22
        end
    end

    // assertion and release delays for the trip
    level_delay u_trip_delay (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .tick_i(tick),
        .on_dly_i(assert_dly_q),
        .off_dly_i(release_dly_q),
        .level_i(trip_latched_q),
        .level_o(trip_delayed)
    );

    // timer function: high a set time after the trigger, low with it
    level_delay u_timer_delay (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .tick_i(tick),
        .on_dly_i(timer_dly_q),
        .off_dly_i(`RST_DELAY),
        .level_i(timer_trigger_i),
        .level_o(timer_delayed)
    );

    // hysteresis keeps the output from chattering around one level
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            on_off_q <= 1'b0;
        end else if (analog_value_i >= on_level_q) begin
            on_off_q <= 1'b1; // R9
        end else if (analog_value_i <= off_level_q) begin
            on_off_q <= 1'b0; // R9
        end
    end

    // buffering mode is deliberately not an input here
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            buffering_q <= 1'b0;
        end else if (buffering_start_i) begin
            buffering_q <= 1'b1; // R11
        end else if (power_restored_i) begin
            buffering_q <= 1'b0; // R12
        end
    end

    // condition vector
    always_comb begin
        status.run = run_cmd_i & voltage_out_i & ~dc_braking_i; // R20
        status.stop = ~run_cmd_i & ~voltage_out_i; // R1
        status.steady = steady_i; // R2
        status.inv_line = inverter_line_i; // R3
        status.comm_line = comm_line_i; // R4
        status.search = speed_search_i; // R5
        status.ready = ready_i; // R6
        status.timer = timer_delayed; // R7
        status.trip = trip_delayed; // R21
        status.on_off = on_off_q;
        status.brake = brake_release_output_i; // R10
        status.buffering = buffering_q; // R12
    end

    // registered outputs
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            collector_q <= 1'b0;
        end else begin
            collector_q <= pick(collector_fn_q, status); // R13
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            relay_q <= 1'b0;
        end else begin
            relay_q <= pick(relay_fn_q, status); // R13
        end
    end

    assign open_collector_output_o = collector_q;
    assign relay_output_o = relay_q;
    assign trip_latched_o = trip_latched_q;
    assign trip_active_o = trip_delayed;
    assign kinetic_energy_buffering_o = buffering_q;
    assign trip_cause_mask_o = cause_mask_q;

endmodule : drive_status_output_selector

// File: logic/drive_status_pkg.sv
/*
 Types shared by the status output selector and its delay stage.
 Assumes the constants header is included by the users.
*/
package drive_status_pkg;

    typedef logic [5:0] fn_code_t;
    typedef logic [13:0] delay_t;

    typedef enum logic [3:0] {
        DLY_LOW = 4'h1,
        DLY_RISE = 4'h2,
        DLY_HIGH = 4'h4,
        DLY_FALL = 4'h8
    } delay_state_t;

    typedef struct packed {
        logic run;
        logic stop;
        logic steady;
        logic inv_line;
        logic comm_line;
        logic search;
        logic ready;
        logic timer;
        logic trip;
        logic on_off;
        logic brake;
        logic buffering;
    } status_t;

endpackage : drive_status_pkg

// File: logic/level_delay.sv
/*
 On/off delay of a level, counted in time-base ticks.
 Assumes tick_i is a one-cycle enable from the divider.
*/
`timescale 1ns/1ps
`include "drive_status_defines.svh"

module level_delay (
    // clock, reset and time-base tick
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic tick_i,
    // settings, in ticks
    input wire drive_status_pkg::delay_t on_dly_i,
    input wire drive_status_pkg::delay_t off_dly_i,
    // level in and out
    input wire logic level_i,
    output logic level_o
);

    drive_status_pkg::delay_state_t state_q;
    drive_status_pkg::delay_t cnt_q;

    // a toggle during a wait returns to the old state and clears the count
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q <= drive_status_pkg::DLY_LOW;
            cnt_q <= `RST_DELAY;
        end else begin
            case (state_q)
                drive_status_pkg::DLY_LOW: begin
                    cnt_q <= `RST_DELAY;
                    if (level_i) begin
                        state_q <= (on_dly_i == `RST_DELAY) ? drive_status_pkg::DLY_HIGH
                                                             : drive_status_pkg::DLY_RISE;
                    end
                end
                drive_status_pkg::DLY_RISE: begin
                    if (!level_i) begin
                        state_q <= drive_status_pkg::DLY_LOW; // R23
                    end else if (tick_i) begin
                        if (cnt_q + 14'h1 >= on_dly_i) begin
                            state_q <= drive_status_pkg::DLY_HIGH; // R21
                        end
                        cnt_q <= cnt_q + 14'h1;
                    end
                end
                drive_status_pkg::DLY_HIGH: begin
                    cnt_q <= `RST_DELAY;
                    if (!level_i) begin
                        state_q <= (off_dly_i == `RST_DELAY) ? drive_status_pkg::DLY_LOW
                                                              : drive_status_pkg::DLY_FALL;
                    end
                end
                drive_status_pkg::DLY_FALL: begin
                    if (level_i) begin
                        state_q <= drive_status_pkg::DLY_HIGH; // R23
                    end else if (tick_i) begin
                        if (cnt_q + 14'h1 >= off_dly_i) begin
                            state_q <= drive_status_pkg::DLY_LOW; // R22
                        end
                        cnt_q <= cnt_q + 14'h1;
                    end
                end
                default: begin
                    state_q <= drive_status_pkg::DLY_LOW;
                    cnt_q <= `RST_DELAY;
                end
            endcase
        end
    end

    assign level_o = (state_q == drive_status_pkg::DLY_HIGH) ||
                     (state_q == drive_status_pkg::DLY_FALL);

endmodule : level_delay

// File: logic/tick_divider.sv
/*
 Divides the system clock into a one-cycle enable every TICK_CYCLES.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "drive_status_defines.svh"

module tick_divider #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // time base
    output logic tick_o
);

    logic [31:0] cnt_q;
    logic tick_q;

    // 10 ms base; shortened in simulation through the parameter
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (cnt_q == 32'(TICK_CYCLES - 1)) begin
            cnt_q <= 32'h0;
            tick_q <= 1'b1; // R23
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    assign tick_o = tick_q;

endmodule : tick_divider
